// ===== verilog/hbu_host_bus_unit.sv
// Host bus unit: parallel processor port onto the internal RAM arbiter.
// Assumes all host pins are asynchronous and the RAM answers one cycle
// after its request is granted.
`timescale 1ns/1ps
// Notes on behaviour
// - 8-bit data, 11-bit address, sync or async
// - Family pin picks strobes and byte order
// - Timing pin picks rigid or asynchronous timing
// - Sync E-clock: no ready, non-multiplexed bus
// - Sync E-clock: decoder off, external select
// - Async E-clock: ready driven, non-multiplexed bus
// - Async E-clock: decoder off, external select
// - Sync strobe mode: rigid, muxed address/data
// - Sync strobe mode: internal latch and decoder
// - Latch low address, window 00000xxx, select tied high
// - E-clock family swaps bytes of word cells
// - Async strobe mode: decoder off, ready driven
// - Host wins simultaneous RAM access
module hbu_host_bus_unit
  import hbu_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Static configuration pins
  input  wire logic          family_select_pin,   // 1: E-clock family
  input  wire logic          timing_select_pin,   // 1: synchronous rigid
  input  wire logic          divider_select_pin,  // 1: /2, 0: /4
  // Host control pins
  input  wire logic          chip_select_n,
  input  wire logic          write_strobe_n,      // E clock in E family
  input  wire logic          read_strobe_n,       // Read/write in E family
  input  wire logic          addr_latch_strobe,
  input  wire logic [AW-1:0] address_bus_lines,
  // Host data pins, also low address in multiplexed mode
  input  wire logic [DW-1:0] data_bus_lines_in,
  output logic [DW-1:0]      data_bus_lines_out,
  output logic               data_bus_lines_oe,
  // Ready handshake pin
  output logic               wait_ready_out,
  output logic               wait_ready_oe,
  // Divided clock output
  output logic               divided_clock_out,
  // Sequencer RAM port
  input  wire logic          seq_req,
  input  wire logic          seq_we,
  input  wire logic [AW-1:0] seq_addr,
  input  wire logic [DW-1:0] seq_wdata,
  output logic               seq_gnt,
  // RAM port
  output logic               ram_en,
  output logic               ram_we,
  output logic [AW-1:0]      ram_addr,
  output logic [DW-1:0]      ram_wdata,
  input  wire logic [DW-1:0] ram_rdata
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 7 + AW + DW;              // Synchronised pin count
  logic [SW-1:0] pin_meta_r;                    // First stage only
  logic [SW-1:0] pin_sync_r;                    // Safe to read
  logic          fam_s;                         // E-clock family
  logic          tim_s;                         // Rigid timing
  logic          div_s;                         // Divide-by-two
  logic          cs_n_s;
  logic          wr_n_s;
  logic          rd_n_s;
  logic          ale_s;
  logic [AW-1:0] addr_s;
  logic [DW-1:0] data_s;

  // Two flops for every pin; the first is read by nothing else
  // Reset to idle pin levels, else a zero select and strobe fake an access
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_r <= {PIN_IDLE_RST, {(AW+DW){1'b0}}};
      pin_sync_r <= {PIN_IDLE_RST, {(AW+DW){1'b0}}};
    end
    else
    begin
      pin_meta_r <= {family_select_pin, timing_select_pin, divider_select_pin,
                     chip_select_n, write_strobe_n, read_strobe_n,
                     addr_latch_strobe, address_bus_lines, data_bus_lines_in};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign {fam_s, tim_s, div_s, cs_n_s, wr_n_s, rd_n_s, ale_s, addr_s, data_s}
    = pin_sync_r;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic          int_dec;                       // Internal decoder in use
  logic          ready_en;                      // Ready handshake in use
  logic [DW-1:0] lat_r;                         // Latched low address
  logic          sel;                           // Device selected
  logic          active;                        // Strobe phase of an access
  logic          is_read;                       // Access direction
  logic [AW-1:0] acc_addr;                      // Full host address

  // Configuration pins are trusted static, so no capture register
  assign int_dec  = !fam_s && tim_s;
  assign ready_en = !tim_s;

  // Low address follows the shared bus while the latch strobe is high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lat_r <= DOUT_RST;
    else if (ale_s && int_dec)
      lat_r <= data_s;
  end

  // Select from fixed window or from the external pin
  always_comb
  begin
    if (int_dec)
    begin
      sel      = (lat_r[DW-1:DEC_HI_LSB] == DEC_WINDOW_HI);
      acc_addr = {addr_s[AW-1:DW], lat_r};
    end
    else
    begin
      sel      = !cs_n_s;
      acc_addr = addr_s;
    end
    // Strobe style per family
    if (fam_s)
    begin
      active  = sel && wr_n_s;
      is_read = rd_n_s;
    end
    else
    begin
      active  = sel && (!rd_n_s || !wr_n_s);
      is_read = !rd_n_s;
    end
  end

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  hbu_state_t    state_r;
  hbu_state_t    state_nxt;
  logic          active_d_r;                    // Previous strobe phase
  logic          rd_r;                          // Direction of this access
  logic [AW-1:0] acc_addr_r;                    // Host address of access
  logic [AW-1:0] ram_addr_h;                    // Address after byte swap
  logic [DW-1:0] wdata_r;                       // Last sampled write data
  logic          host_req;
  logic          host_gnt;
  logic          start;

  assign start = active && !active_d_r;

  // Word cells map byte 0 and byte 1 the other way round
  assign ram_addr_h = (fam_s && hbu_swap_hit(acc_addr_r))
                    ? (acc_addr_r ^ 11'h001) : acc_addr_r;
  assign host_req   = (state_r == HBU_RD_REQ) || (state_r == HBU_WR_REQ);

  // Next state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      HBU_IDLE:
        if (start)
          state_nxt = is_read ? HBU_RD_REQ : HBU_HOLD;
      HBU_RD_REQ:
        if (host_gnt)
          state_nxt = HBU_RD_WAIT;
      HBU_RD_WAIT:
        state_nxt = HBU_HOLD;
      HBU_HOLD:
        // Write data is only safe at the trailing edge of the strobe
        if (!active)
          state_nxt = rd_r ? HBU_IDLE : HBU_WR_REQ;
      HBU_WR_REQ:
        if (host_gnt)
          state_nxt = HBU_IDLE;
      default:
        state_nxt = HBU_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r    <= HBU_IDLE;
      active_d_r <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      active_d_r <= active;
    end
  end

  // Access capture
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_r       <= 1'b0;
      acc_addr_r <= '0;
      wdata_r    <= DOUT_RST;
    end
    else
    begin
      if (state_r == HBU_IDLE && start)
      begin
        rd_r       <= is_read;
        acc_addr_r <= acc_addr;
      end
      if (state_r == HBU_HOLD && active)
        wdata_r <= data_s;
    end
  end

  // Read data register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      data_bus_lines_out <= DOUT_RST;
    else if (state_r == HBU_RD_WAIT)
      data_bus_lines_out <= ram_rdata;
  end

  // Bus drive and ready pin
  assign data_bus_lines_oe = active && rd_r && (state_r == HBU_HOLD);
  assign wait_ready_oe     = ready_en && sel;
  assign wait_ready_out    = (state_r == HBU_HOLD);

  // ----------------------------------------------------------------
  // Clock divider
  // ----------------------------------------------------------------
  logic [1:0] div_cnt_r;
  logic       div_tick;

  // Toggle each cycle for /2, every second cycle for /4
  assign div_tick = div_s || div_cnt_r[0];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt_r         <= DIV_RST;
      divided_clock_out <= 1'b0;
    end
    else
    begin
      div_cnt_r <= div_cnt_r + 2'h1;
      if (div_tick)
        divided_clock_out <= !divided_clock_out;
    end
  end

  // ----------------------------------------------------------------
  // RAM arbitration
  // ----------------------------------------------------------------
  hbu_ram_arbiter u_arb (
    .host_req   (host_req),
    .host_we    (state_r == HBU_WR_REQ),
    .host_addr  (ram_addr_h),
    .host_wdata (wdata_r),
    .host_gnt   (host_gnt),
    .seq_req    (seq_req),
    .seq_we     (seq_we),
    .seq_addr   (seq_addr),
    .seq_wdata  (seq_wdata),
    .seq_gnt    (seq_gnt),
    .ram_en     (ram_en),
    .ram_we     (ram_we),
    .ram_addr   (ram_addr),
    .ram_wdata  (ram_wdata)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_no_ready_sync: assert property (@(posedge clk) disable iff (!rst_n)
    tim_s |-> !wait_ready_oe) else $error("ready driven in rigid mode");

  a_ready_async: assert property (@(posedge clk) disable iff (!rst_n)
    (!tim_s && sel && state_r == HBU_HOLD) |-> (wait_ready_oe && wait_ready_out))
    else $error("ready missing in async mode");

  a_window_decode: assert property (@(posedge clk) disable iff (!rst_n)
    int_dec |-> (sel == (lat_r[7:3] == 5'h00)))
    else $error("internal window decode wrong");

  a_ext_select: assert property (@(posedge clk) disable iff (!rst_n)
    (fam_s || !tim_s) |-> (sel == !cs_n_s))
    else $error("external select ignored");

  a_host_first: assert property (@(posedge clk) disable iff (!rst_n)
    (host_req && seq_req) |-> (!seq_gnt && ram_addr == ram_addr_h))
    else $error("sequencer beat host");

  a_byte_swap: assert property (@(posedge clk) disable iff (!rst_n)
    (host_req && fam_s && hbu_swap_hit(acc_addr_r))
      |-> (ram_addr[0] != acc_addr_r[0]))
    else $error("word cell not swapped");

  a_read_path: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == HBU_RD_REQ && host_gnt) |=> ##1
      (data_bus_lines_out == $past(ram_rdata) && state_r == HBU_HOLD))
    else $error("read data not captured");

  a_div_four: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(divided_clock_out) && !div_s && !$past(div_s)) ##1 !div_s[*3]
      |=> $rose(divided_clock_out))
    else $error("divide by four period wrong");

  a_write_after: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == HBU_HOLD && !rd_r && !active) |=> (host_req && ram_we))
    else $error("write not issued at strobe end");

endmodule : hbu_host_bus_unit

// ===== verilog/hbu_pkg.sv
// Shared constants and types for the host bus unit.
// Assumes a single 125 MHz core clock; all host pins are asynchronous to it.
package hbu_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int AW = 11;                       // Host address width
  localparam int DW = 8;                        // Host data width

  // ----------------------------------------------------------------
  // Internal decoder window: low byte must be 00000xxx
  // ----------------------------------------------------------------
  localparam logic [4:0] DEC_WINDOW_HI = 5'h00; // Required value of bits 7..3
  localparam int         DEC_HI_LSB    = 3;     // Lowest bit of that field

  // ----------------------------------------------------------------
  // Word cells whose byte order flips for the E-clock family
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] SWAP_INT_ADDR  = 11'h002; // Interrupt word
  localparam logic [AW-1:0] SWAP_STAT_ADDR = 11'h004; // Status word
  localparam logic [AW-1:0] SWAP_MODE_ADDR = 11'h006; // Mode word
  localparam logic [AW-1:0] SWAP_WDOG_ADDR = 11'h024; // Watchdog reload word

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DW-1:0] DOUT_RST = 8'h00;   // Read data register
  localparam logic [1:0]    DIV_RST  = 2'h0;    // Divider counter
  // Control pins at rest: select and both strobes high, the rest low
  localparam logic [6:0]    PIN_IDLE_RST = 7'h0E;

  // ----------------------------------------------------------------
  // Access sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HBU_IDLE,
    HBU_RD_REQ,
    HBU_RD_WAIT,
    HBU_HOLD,
    HBU_WR_REQ
  } hbu_state_t;

  // Word cell with swapped byte order
  function automatic logic hbu_swap_hit(input logic [AW-1:0] a);
    logic [AW-1:0] w;
    w = {a[AW-1:1], 1'b0};
    return (w == SWAP_INT_ADDR) || (w == SWAP_STAT_ADDR) ||
           (w == SWAP_MODE_ADDR) || (w == SWAP_WDOG_ADDR);
  endfunction : hbu_swap_hit

endpackage : hbu_pkg

// ===== verilog/hbu_ram_arbiter.sv
// Fixed-priority arbiter in front of the single-port internal RAM.
// Assumes a RAM with one-cycle read latency on the same clock.
`timescale 1ns/1ps
module hbu_ram_arbiter
  import hbu_pkg::*;
(
  // Host side
  input  wire logic          host_req,
  input  wire logic          host_we,
  input  wire logic [AW-1:0] host_addr,
  input  wire logic [DW-1:0] host_wdata,
  output logic               host_gnt,
  // Sequencer side
  input  wire logic          seq_req,
  input  wire logic          seq_we,
  input  wire logic [AW-1:0] seq_addr,
  input  wire logic [DW-1:0] seq_wdata,
  output logic               seq_gnt,
  // RAM side
  output logic               ram_en,
  output logic               ram_we,
  output logic [AW-1:0]      ram_addr,
  output logic [DW-1:0]      ram_wdata
);

  // ----------------------------------------------------------------
  // Grant and mux
  // ----------------------------------------------------------------
  // Host wins a collision: shortest access time for the processor
  always_comb
  begin
    host_gnt = host_req;
    seq_gnt  = seq_req && !host_req;
    ram_en   = host_req || seq_req;
    if (host_req)
    begin
      ram_we    = host_we;
      ram_addr  = host_addr;
      ram_wdata = host_wdata;
    end
    else
    begin
      ram_we    = seq_we && seq_req;
      ram_addr  = seq_addr;
      ram_wdata = seq_wdata;
    end
  end

endmodule : hbu_ram_arbiter

// ===== verification/hbu_host_model.sv
// Host processor model for the parallel port of the host bus unit.
// Assumes one caller at a time and a device clock at least ten host strobes fast.
`timescale 1ns/1ps
module hbu_host_model
  import hbu_pkg::*;
(
  // Clock and mode pins
  input  wire logic          clk,
  input  wire logic          family_select_pin,
  input  wire logic          timing_select_pin,
  // Pins driven toward the device
  output logic               chip_select_n,
  output logic               write_strobe_n,
  output logic               read_strobe_n,
  output logic               addr_latch_strobe,
  output logic [AW-1:0]      address_bus_lines,
  output logic [DW-1:0]      data_bus_lines_in,
  // Answer pins from the device
  input  wire logic [DW-1:0] data_bus_lines_out,
  input  wire logic          data_bus_lines_oe,
  input  wire logic          wait_ready_out,
  input  wire logic          wait_ready_oe
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // 80 ns strobe phase, 160 ns host cycle: core clock is 20 times faster
  localparam int HALF = 10;
  logic saw_rdy;            // Ready pin driven during last access
  logic tmo;                // Ready wait ran out

  // Bus lines start at a known level
  initial
  begin
    address_bus_lines = '0;
    data_bus_lines_in = '0;
  end

  // Idle pins; E clock idles low, strobes idle high
  task automatic park(input logic f);
    chip_select_n     <= 1'b1;
    write_strobe_n    <= !f;
    read_strobe_n     <= 1'b1;
    addr_latch_strobe <= 1'b0;
  endtask : park

  // One byte access; request held until ready or the rigid phase ends
  task automatic xfer(input logic we, input logic [AW-1:0] a, input logic [DW-1:0] wd,
                      input logic csn, output logic [DW-1:0] rd);
    int n;
    saw_rdy = 1'b0;
    tmo     = 1'b0;
    @(posedge clk);
    address_bus_lines <= a;
    chip_select_n     <= csn;
    if (family_select_pin)
      read_strobe_n <= !we;
    if (!family_select_pin && timing_select_pin)
    begin
      // Muxed address phase on the data lines
      addr_latch_strobe <= 1'b1;
      data_bus_lines_in <= a[7:0];
      repeat (4) @(posedge clk);
      addr_latch_strobe <= 1'b0;
      @(posedge clk);
    end
    // Released bus on reads carries a changing pattern, not the data
    data_bus_lines_in <= we ? wd : ~wd;
    if (family_select_pin)
      write_strobe_n <= 1'b1;
    else if (we)
      write_strobe_n <= 1'b0;
    else
      read_strobe_n <= 1'b0;
    n = 0;
    if (timing_select_pin)
    begin
      // Rigid timing: fixed phase, ready pin ignored
      repeat (HALF)
      begin
        @(posedge clk);
        saw_rdy |= wait_ready_oe;
      end
    end
    else
    begin
      // Asynchronous timing: wait for ready, bounded
      do
      begin
        @(posedge clk);
        n++;
      end while (!(wait_ready_oe && wait_ready_out) && n < 40);
      saw_rdy = wait_ready_oe;
      tmo     = (n >= 40);
    end
    rd = data_bus_lines_oe ? data_bus_lines_out : 8'hXX;
    park(family_select_pin);
    data_bus_lines_in <= ~data_bus_lines_in;
    repeat (HALF) @(posedge clk);
  endtask : xfer
endmodule : hbu_host_model

// ===== verification/hbu_host_bus_unit_tb.sv
// Self-checking bench for the host bus unit in all four port modes.
// Assumes a one-cycle RAM model here and the host model beside it.
`timescale 1ns/1ps
module hbu_host_bus_unit_tb;
  import hbu_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, rst_n, fam, tim, div, csn, wsn, rsn, ale, dboe, rdy, rdyoe, dclk;
  logic          seq_req, seq_gnt, ram_en, ram_we;
  logic [AW-1:0] abus, ram_addr;
  logic [DW-1:0] din, dout, ram_wdata, ram_rdata, r;
  logic [DW-1:0] mem [2**AW];  // Internal RAM model
  int            fails, checks;

  hbu_host_bus_unit i_dut (
    .clk(clk), .rst_n(rst_n), .family_select_pin(fam), .timing_select_pin(tim),
    .divider_select_pin(div), .chip_select_n(csn), .write_strobe_n(wsn),
    .read_strobe_n(rsn), .addr_latch_strobe(ale), .address_bus_lines(abus),
    .data_bus_lines_in(din), .data_bus_lines_out(dout), .data_bus_lines_oe(dboe),
    .wait_ready_out(rdy), .wait_ready_oe(rdyoe), .divided_clock_out(dclk),
    .seq_req(seq_req), .seq_we(1'b1), .seq_addr(11'h7F0), .seq_wdata(8'h5A),
    .seq_gnt(seq_gnt), .ram_en(ram_en), .ram_we(ram_we), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));

  hbu_host_model i_host (
    .clk(clk), .family_select_pin(fam), .timing_select_pin(tim), .chip_select_n(csn),
    .write_strobe_n(wsn), .read_strobe_n(rsn), .addr_latch_strobe(ale),
    .address_bus_lines(abus), .data_bus_lines_in(din), .data_bus_lines_out(dout),
    .data_bus_lines_oe(dboe), .wait_ready_out(rdy), .wait_ready_oe(rdyoe));

  // Clock, 8 ns
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // RAM with one-cycle read latency
  always @(posedge clk)
  begin
    if (ram_en && ram_we)
      mem[ram_addr] <= ram_wdata;
    ram_rdata <= mem[ram_addr];
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check8(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask : check8

  task automatic check1(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask : check1

  // Access; a ready wait that runs out counts as a mismatch
  task automatic acc(input logic we, input logic [AW-1:0] a, input logic [DW-1:0] wd,
                     input logic cs);
    i_host.xfer(we, a, wd, cs, r);
    check1(i_host.tmo, 1'b0);
  endtask : acc

  // Pins change only under reset, so they are static while operating
  task automatic set_mode(input logic f, input logic t);
    rst_n <= 1'b0;
    fam   <= f;
    tim   <= t;
    i_host.park(f);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : set_mode

  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  // Hang guard
  initial
  begin
    #700000;
    fails++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [AW-1:0] a;
    int            e;
    logic          p;
    fails = 0; checks = 0; rst_n = 1'b0; fam = 1'b0; tim = 1'b0; div = 1'b0;
    seq_req = 1'b1;
    foreach (mem[i]) mem[i] = 8'h00;
    // Every mode, with the sequencer pressing for the RAM all along
    for (int m = 0; m < 4; m++)
    begin
      set_mode(m[1], m[0]);
      a = {1'b0, m[1:0], 8'h03};
      acc(1'b1, a, 8'hC0 | m[7:0], !m[1] && m[0]);
      acc(1'b0, a, 8'h00, !m[1] && m[0]);
      check8(r, 8'hC0 | m[7:0]);
      check1(i_host.saw_rdy, !m[0]);
    end
    check1(seq_gnt, 1'b1);
    seq_req <= 1'b0;
    check8(mem[11'h7F0], 8'h5A);
    // Word cells swap bytes in the E-clock family only
    set_mode(1'b1, 1'b1);
    acc(1'b1, 11'h004, 8'h12, 1'b0);
    acc(1'b1, 11'h024, 8'h34, 1'b0);
    acc(1'b1, 11'h010, 8'h56, 1'b0);
    check8(mem[11'h005], 8'h12);
    check8(mem[11'h025], 8'h34);
    check8(mem[11'h010], 8'h56);
    set_mode(1'b0, 1'b0);
    acc(1'b1, 11'h006, 8'h78, 1'b0);
    check8(mem[11'h006], 8'h78);
    // Deselected E access and out-of-window muxed access are ignored
    set_mode(1'b1, 1'b0);
    i_host.xfer(1'b1, 11'h020, 8'h77, 1'b1, r);
    check8(mem[11'h020], 8'h00);
    set_mode(1'b0, 1'b1);
    acc(1'b1, 11'h108, 8'h99, 1'b1);
    check8(mem[11'h108], 8'h00);
    // Divided clock: rising edges in 64 cycles
    for (int d = 0; d < 2; d++)
    begin
      @(posedge clk);
      div <= d[0];
      set_mode(1'b1, 1'b1);
      e = 0;
      #1;
      p = dclk;
      repeat (64)
      begin
        @(posedge clk);
        #1;
        if (dclk && !p) e++;
        p = dclk;
      end
      check8(e[7:0], d ? 8'h20 : 8'h10);
    end
    print_verdict();
  end
endmodule : hbu_host_bus_unit_tb
